//--- rtl/fault_pkg.sv
package fault_pkg;

  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] ctrl_addr      = 8'h00;
  localparam logic [7:0] status_addr    = 8'h04;
  localparam logic [7:0] state_addr     = 8'h08;
  localparam logic [7:0] ot_limit_addr  = 8'h0c;
  localparam logic [7:0] moc_limit_addr = 8'h10;
  localparam logic [7:0] live_addr      = 8'h14;

  // ctrl fields
  localparam int ctrl_restart_bit = 0;
  localparam int ctrl_ovp_en_bit  = 1;
  localparam int ctrl_run_bit     = 2;

  localparam logic [31:0] ctrl_reset     = 32'h0000_0006;
  localparam logic [11:0] ot_limit_reset = 12'h7d0;

  // latch bit positions
  localparam int num_faults   = 12;
  localparam int f_boost_uv   = 0;
  localparam int f_gate_uv    = 1;
  localparam int f_limit_res  = 2;
  localparam int f_addr_res   = 3;
  localparam int f_ss_dis     = 4;
  localparam int f_fet_short  = 5;
  localparam int f_start_oc   = 6;
  localparam int f_severe_oc  = 7;
  localparam int f_safe_oc    = 8;
  localparam int f_overtemp   = 9;
  localparam int f_input_ov   = 10;
  localparam int f_external   = 11;

  // timing
  localparam int  clk_hz          = 40_000_000;
  localparam real safe_trip_ns    = 250.0;
  localparam real start_trip_us   = 10.0;
  localparam real good_delay_ms   = 5.0;
  localparam real gate_mask_ms    = 100.0;
  localparam int  safe_trip_cyc   = int'(safe_trip_ns * clk_hz / 1.0e9);
  localparam int  start_trip_cyc  = int'(start_trip_us * clk_hz / 1.0e6);
  localparam int  good_delay_cyc  = int'(good_delay_ms * clk_hz / 1.0e3);
  localparam int  gate_mask_cyc   = int'(gate_mask_ms * clk_hz / 1.0e3);

  typedef enum logic [3:0] {
    st_off   = 4'b0001,
    st_ramp  = 4'b0010,
    st_wait  = 4'b0100,
    st_good  = 4'b1000
  } seq_e;

endpackage

//--- rtl/sense_if.sv
`timescale 1ns/10ps
interface sense_if #(parameter int w = 12);
  logic [w-1:0] raw;
  logic [w-1:0] sync;
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface

//--- rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int w = 12
) (
  input  wire logic clk,
  input  wire logic rst,
  sense_if.dst      s
);
  logic [w-1:0] stage1_r;
  logic [w-1:0] stage2_r;

  // every bit is independent; first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= s.raw;
      stage2_r <= stage1_r;
    end
  end

  assign s.sync = stage2_r;
endmodule

//--- rtl/delay_count.sv
`timescale 1ns/10ps
module delay_count #(
  parameter int count = 200000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      done
);
  localparam int cw = $clog2(count + 1);
  logic [cw-1:0] cnt_r;

  // restarts whenever run drops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (!run) begin
      cnt_r <= '0;
    end else if (cnt_r != cw'(count)) begin
      cnt_r <= cnt_r + cw'(1);
    end
  end

  assign done = run && (cnt_r == cw'(count));
endmodule

//--- rtl/protection_fault_manager.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
// Behaviour
// - above 60A safe limit: FET off, fault latched
// - limit resistor changes update moderate threshold live
// - overvoltage variant latches; other variant ignores it
// - bad limit resistor latches, always checked
// - latches hold until enable, power, restart toggle
// - overtemperature above programmable limit latches
// - listed detections assert fault and latch
// - undervoltage: FET off only, no latch
// - boost undervoltage before startup ignored entirely
// - undervoltage releases fault pin, clears latches
// - any latch pulls fault pin low immediately
// - external low on fault pin latches
// - power good only after startup with good output
// - power good low in every other state
// - 5ms wait after gate resistive before good
// - gate undervoltage masked 100ms during startup
// - startup overcurrent before good: off within 10us
module protection_fault_manager
  import fault_pkg::*;
#(
  parameter bit   has_ovp        = 1'b1,
  parameter int   good_delay     = good_delay_cyc,
  parameter int   gate_mask      = gate_mask_cyc
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        enable_threshold_in,
  input  wire logic        safe_oc_in,
  input  wire logic        severe_oc_in,
  input  wire logic        moderate_oc_in,
  input  wire logic        start_oc_in,
  input  wire logic        limit_resistor_bad,
  input  wire logic        address_resistor_bad,
  input  wire logic        input_overvoltage_trip,
  input  wire logic        boost_rail_uv,
  input  wire logic        gate_drive_level_uv,
  input  wire logic        softstart_cap_fail,
  input  wire logic        fet_short,
  input  wire logic        output_above_good,
  input  wire logic        gate_drive_resistive,
  input  wire logic [11:0] temp_code,
  input  wire logic [7:0]  limit_resistor_sense,
  input  wire logic        fault_n_in,
  output logic             fault_n_out,
  output logic             fault_n_oe,
  output logic             supply_ok_out,
  output logic             supply_ok_oe,
  output logic             fet_enable,
  output logic [7:0]       moderate_oc_level
);

  localparam int nsync = 12;

  sense_if #(.w(nsync)) bits_if ();
  sense_if #(.w(8))     res_if ();
  sense_if #(.w(12))    tmp_if ();

  // fault line rides inverted: the synchroniser resets to zero, which must read as no fault
  assign bits_if.raw = {~fault_n_in, enable_threshold_in, safe_oc_in, severe_oc_in,
                        start_oc_in, limit_resistor_bad, address_resistor_bad,
                        input_overvoltage_trip, boost_rail_uv, gate_drive_level_uv,
                        softstart_cap_fail, fet_short};
  assign res_if.raw  = limit_resistor_sense;
  assign tmp_if.raw  = temp_code;

  pin_sync #(.w(nsync)) u_sync_bits (.clk(clk), .rst(rst), .s(bits_if));
  pin_sync #(.w(8))     u_sync_res  (.clk(clk), .rst(rst), .s(res_if));
  pin_sync #(.w(12))    u_sync_tmp  (.clk(clk), .rst(rst), .s(tmp_if));

  logic ext_low_s, en_s, safe_s, severe_s, start_s, lres_s, ares_s;
  logic ov_s, boost_s, gate_s, ss_s, short_s;
  assign {ext_low_s, en_s, safe_s, severe_s, start_s, lres_s, ares_s,
          ov_s, boost_s, gate_s, ss_s, short_s} = bits_if.sync;

  logic                  good_q;
  logic                  mod_q;
  seq_e                  state_r;
  logic                  fault_n_oe_r;
  logic [2:0]            oe_hist_r;
  assign good_q = (state_r == st_good);

  // sync path only two cycles, well inside 250ns (10 cycles) and 10us
  logic [31:0]           ctrl_r;
  logic [11:0]           ot_limit_r;
  logic [num_faults-1:0] latch_r;
  logic [num_faults-1:0] detect;
  logic                  restart_pulse;
  logic                  en_prev_r;
  logic                  gate_masked;
  logic                  good_done;
  logic                  mask_done;

  always_comb begin
    detect               = '0;
    detect[f_safe_oc]    = safe_s;
    detect[f_severe_oc]  = severe_s;
    detect[f_start_oc]   = start_s && !good_q && state_r != st_off;
    detect[f_limit_res]  = lres_s;
    detect[f_addr_res]   = ares_s;
    detect[f_input_ov]   = has_ovp && ctrl_r[ctrl_ovp_en_bit] && ov_s;
    detect[f_boost_uv]   = boost_s && state_r != st_off;
    detect[f_gate_uv]    = gate_s && !gate_masked;
    detect[f_ss_dis]     = ss_s && state_r != st_off;
    detect[f_fet_short]  = short_s && state_r != st_off;
    detect[f_overtemp]   = tmp_if.sync > ot_limit_r;
    // our own low needs two cycles to leave the synchroniser after release
    detect[f_external]   = ext_low_s && !fault_n_oe_r && !(|oe_hist_r);
  end

  assign mod_q = moderate_oc_in;

  // apb
  logic apb_wr;
  logic apb_rd;
  logic mapped;
  logic supply_ok_oe_r;
  logic fet_enable_r;
  logic [7:0] moc_level_r;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ctrl_addr) || (a == status_addr) || (a == state_addr) ||
                (a == ot_limit_addr) || (a == moc_limit_addr) || (a == live_addr);
  endfunction

  assign mapped = is_mapped(paddr);
  assign restart_pulse = apb_wr && mapped && paddr == ctrl_addr &&
                         pwdata[ctrl_restart_bit];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r     <= ctrl_reset;
      ot_limit_r <= ot_limit_reset;
    end else if (apb_wr && paddr == ctrl_addr) begin
      ctrl_r     <= {29'h0, pwdata[2:1], 1'b0};
    end else if (apb_wr && paddr == ot_limit_addr) begin
      ot_limit_r <= pwdata[11:0];
    end
  end

  // no wait state: pready high in first access cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (apb_rd) begin
        case (paddr)
          ctrl_addr:      prdata <= ctrl_r;
          status_addr:    prdata <= {{(32-num_faults){1'b0}}, latch_r};
          state_addr:     prdata <= {28'h0, state_r};
          ot_limit_addr:  prdata <= {20'h0, ot_limit_r};
          moc_limit_addr: prdata <= {24'h0, moc_level_r};
          live_addr:      prdata <= {20'h0, detect};
          default:        prdata <= 32'h0;
        endcase
      end
    end
  end

  // clearing actions: enable low, restart command, reset (power)
  logic clear_all;
  assign clear_all = !en_s || restart_pulse;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_r <= '0;
    end else if (clear_all) begin
      latch_r <= '0;
    end else begin
      latch_r <= latch_r | detect;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_prev_r <= 1'b0;
    end else begin
      en_prev_r <= en_s;
    end
  end

  // recent history of our own drive of the fault line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_hist_r <= '0;
    end else begin
      oe_hist_r <= {oe_hist_r[1:0], fault_n_oe_r};
    end
  end

  // sequencer
  logic any_latch;
  assign any_latch = |latch_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= st_off;
    end else if (!en_s || any_latch || restart_pulse || !ctrl_r[ctrl_run_bit]) begin
      state_r <= st_off;
    end else begin
      case (state_r)
        st_off:  state_r <= st_ramp;
        st_ramp: if (gate_drive_resistive && output_above_good) state_r <= st_wait;
        st_wait: begin
          if (!(gate_drive_resistive && output_above_good)) state_r <= st_ramp;
          else if (good_done) state_r <= st_good;
        end
        st_good: if (!output_above_good) state_r <= st_ramp;
        default: state_r <= st_off;
      endcase
    end
  end

  delay_count #(.count(good_delay)) u_good (
    .clk  (clk),
    .rst  (rst),
    .run  (state_r == st_wait),
    .done (good_done)
  );

  // mask counts from start of ramp
  delay_count #(.count(gate_mask)) u_mask (
    .clk  (clk),
    .rst  (rst),
    .run  (state_r != st_off),
    .done (mask_done)
  );
  assign gate_masked = !mask_done;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fet_enable_r   <= 1'b0;
      fault_n_oe_r   <= 1'b0;
      supply_ok_oe_r <= 1'b1;
      moc_level_r    <= 8'h00;
    end else begin
      fet_enable_r   <= en_s && !any_latch && !(|detect) && state_r != st_off;
      fault_n_oe_r   <= any_latch && !clear_all;
      supply_ok_oe_r <= !(state_r == st_good && en_s && !any_latch);
      moc_level_r    <= res_if.sync;
    end
  end

  assign fet_enable        = fet_enable_r;
  assign fault_n_oe        = fault_n_oe_r;
  assign fault_n_out       = 1'b0;
  assign supply_ok_oe      = supply_ok_oe_r;
  assign supply_ok_out     = 1'b0;
  assign moderate_oc_level = moc_level_r;
  // moderate overcurrent timing lives in the analog timer; its trip arrives as severe_oc_in
  logic unused_mod;
  assign unused_mod = mod_q & en_prev_r;

endmodule

//--- testbench/pfm_properties.sv
`timescale 1ns/10ps
module pfm_properties
  import fault_pkg::*;
#(
  parameter int good_delay = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        enable_threshold_in,
  input wire logic        safe_oc_in,
  input wire logic        fault_n_in,
  input wire logic        fault_n_oe,
  input wire logic        supply_ok_oe,
  input wire logic        fet_enable,
  input wire logic        gate_drive_resistive,
  input wire logic [7:0]  limit_resistor_sense,
  input wire logic [7:0]  moderate_oc_level
);
  logic [3:0] quiet_r;
  int         held_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // cycles since a permitted clear; saturates so it never wraps into a false pass
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      quiet_r <= 4'h0;
    else if (!enable_threshold_in || (psel && penable && pready && pwrite
             && paddr == ctrl_addr && pwdata[ctrl_restart_bit]))
      quiet_r <= 4'h0;
    else if (quiet_r != 4'hf)
      quiet_r <= quiet_r + 4'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      held_r <= 0;
    else if (!gate_drive_resistive)
      held_r <= 0;
    else if (held_r < 1000000)
      held_r <= held_r + 1;
  end
  AST_SAFE_FET_OFF:
    assert property ($rose(safe_oc_in) |-> ##[1:10] !fet_enable)
    else $error("fet on after safe overcurrent");
  AST_LATCH_PIN:
    assert property ((safe_oc_in && enable_threshold_in) [*6] |-> fault_n_oe)
    else $error("fault pin not driven");
  AST_UV_NO_FAULT:
    assert property (!enable_threshold_in [*8] |-> !fault_n_oe && !fet_enable && supply_ok_oe)
    else $error("undervoltage left fault or fet");
  AST_HOLD_UNTIL_CLEAR:
    assert property ($fell(fault_n_oe) |-> quiet_r < 4'h8)
    else $error("fault released without clear");
  AST_GOOD_DELAY:
    assert property ($fell(supply_ok_oe) |-> held_r >= good_delay)
    else $error("power good too early");
  AST_GOOD_NEEDS_FET:
    assert property ($fell(fet_enable) |-> ##[0:3] supply_ok_oe)
    else $error("power good kept with fet off");
  AST_LEVEL_TRACK:
    assert property ($stable(limit_resistor_sense) [*5] |-> moderate_oc_level == limit_resistor_sense)
    else $error("moderate level not tracking");
  AST_EXT_FAULT:
    assert property ((!fault_n_in && enable_threshold_in) [*6] |-> fault_n_oe)
    else $error("external fault not latched");
  cover property ($rose(safe_oc_in) ##[1:10] fault_n_oe);
  cover property ($fell(supply_ok_oe));
  cover property ($fell(fault_n_oe) && enable_threshold_in);
endmodule
bind protection_fault_manager pfm_properties #(.good_delay(good_delay)) props (
  .clk, .rst, .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .enable_threshold_in,
  .safe_oc_in, .fault_n_in, .fault_n_oe, .supply_ok_oe, .fet_enable, .gate_drive_resistive,
  .limit_resistor_sense, .moderate_oc_level);

//--- testbench/fault_line_model.sv
`timescale 1ns/10ps
module fault_line_model (
  input  wire logic fault_n_out,
  input  wire logic fault_n_oe,
  input  wire logic supply_ok_out,
  input  wire logic supply_ok_oe,
  input  wire logic ext_pull,
  output logic      fault_n_in,
  output logic      power_good
);
  // pull-ups hold both lines high unless someone sinks them
  assign fault_n_in = !(ext_pull || (fault_n_oe && !fault_n_out));
  assign power_good = !(supply_ok_oe && !supply_ok_out);
endmodule

//--- testbench/protection_fault_manager_tb.sv
`timescale 1ns/10ps
module protection_fault_manager_tb;
  import fault_pkg::*;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic        en = 1'h0;
  logic        err;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] src = 12'h0;
  logic [11:0] lim = 12'h0;
  logic [11:0] cool = 12'h0;
  logic [7:0]  lsense = 8'h0;
  logic [31:0] rd;
  logic [31:0] prdata;
  logic [7:0]  mlev;
  logic        pready, pslverr, fout, foe, sout, soe, fet, fin, pg;
  wire  [11:0] temp = src[f_overtemp] ? lim + 12'h1 : cool;
  int          n_errors = 0;
  int          comparisons = 0;

  protection_fault_manager #(.good_delay(20), .gate_mask(50)) DUT (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .enable_threshold_in(en), .safe_oc_in(src[f_safe_oc]), .severe_oc_in(src[f_severe_oc]),
    .moderate_oc_in(1'h0), .start_oc_in(src[f_start_oc]), .limit_resistor_bad(src[f_limit_res]),
    .address_resistor_bad(src[f_addr_res]), .input_overvoltage_trip(src[f_input_ov]),
    .boost_rail_uv(src[f_boost_uv]), .gate_drive_level_uv(src[f_gate_uv]),
    .softstart_cap_fail(src[f_ss_dis]), .fet_short(src[f_fet_short]), .output_above_good(fet),
    .gate_drive_resistive(fet), .temp_code(temp), .limit_resistor_sense(lsense),
    .fault_n_in(fin), .fault_n_out(fout), .fault_n_oe(foe), .supply_ok_out(sout),
    .supply_ok_oe(soe), .fet_enable(fet), .moderate_oc_level(mlev));
  fault_line_model partner (.fault_n_out(fout), .fault_n_oe(foe), .supply_ok_out(sout),
    .supply_ok_oe(soe), .ext_pull(src[f_external]), .fault_n_in(fin), .power_good(pg));

  always #12.5 clk = ~clk;

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int k = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1) begin
      n_errors++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic startup;
    int k = 0;
    while (soe !== 1'h0 && k < 300) begin
      @(posedge clk);
      k++;
    end
    chk("power_good", 32'(pg), 32'h1);
    chk("fet_enable", 32'(fet), 32'h1);
  endtask

  task automatic summarize;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #500000;
    n_errors++;
    summarize;
  end

  initial begin
    int k;
    void'($urandom(53));
    lim = 12'h100 + 12'($urandom % 256);
    cool = 12'($urandom % 256);
    lsense = 8'($urandom);
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, ctrl_addr, 32'h0);
    chk("ctrl", rd, ctrl_reset);
    apb(1'h0, ot_limit_addr, 32'h0);
    chk("ot_limit", rd, 32'(ot_limit_reset));
    apb(1'h0, 8'h18, 32'h0);
    chk("unmapped", 32'(err), 32'h1);
    apb(1'h1, ot_limit_addr, 32'(lim));
    apb(1'h0, ot_limit_addr, 32'h0);
    chk("ot_limit", rd, 32'(lim));
    // sequencing held off and overvoltage check disabled
    apb(1'h1, ctrl_addr, 32'h0);
    en <= 1'h1;
    src <= 12'((1 << f_boost_uv) | (1 << f_input_ov));
    repeat (10) @(posedge clk);
    src <= 12'h0;
    chk("fault_pin", 32'(foe), 32'h0);
    apb(1'h0, status_addr, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'h1, ctrl_addr, ctrl_reset);
    src <= 12'(1 << f_gate_uv);
    repeat (6) @(posedge clk);
    src <= 12'h0;
    startup;
    apb(1'h0, status_addr, 32'h0);
    chk("status", rd, 32'h0);
    for (int j = 0; j < 3; j++) begin
      lsense <= 8'($urandom);
      repeat (6) @(posedge clk);
      chk("level", 32'(mlev), 32'(lsense));
    end
    for (int i = 0; i < num_faults; i++) begin
      repeat (i == f_start_oc ? 2 : 60) @(posedge clk);
      if (i != f_start_oc)
        startup;
      src <= 12'(1 << i); // severe and safe trips come as separate tiers
      k = 0;
      while (foe !== 1'h1 && k < 440) begin
        @(posedge clk);
        k++;
      end
      chk("trip_time", 32'(k <= (i == f_safe_oc ? safe_trip_cyc : start_trip_cyc)), 32'h1);
      repeat (4) @(posedge clk);
      chk("fet_enable", 32'(fet), 32'h0);
      chk("power_good", 32'(pg), 32'h0);
      src <= 12'h0;
      apb(1'h0, status_addr, 32'h0);
      chk("status", rd, 32'(1 << i));
      chk("fault_pin", 32'(fin), 32'h0);
      if (i % 2) begin
        en <= 1'h0;
        repeat (8) @(posedge clk);
        chk("pg_drive", 32'(soe), 32'h1);
        en <= 1'h1;
      end else
        apb(1'h1, ctrl_addr, ctrl_reset | 32'h1);
      repeat (4) @(posedge clk);
      chk("fault_pin", 32'(foe), 32'h0);
      apb(1'h0, status_addr, 32'h0);
      chk("status", rd, 32'h0);
    end
    summarize;
  end
endmodule
